// *** inc/scp_defs.svh ***
`ifndef SCP_DEFS_SVH
`define SCP_DEFS_SVH
`define SCP_INSTR_BITS       16
`define SCP_ADDR_BITS        15
`define SCP_BYTE_BITS        8
`define SCP_DIR_BIT          15
`define SCP_CFG_ADDR         15'h0000
`define SCP_CFG_RESET        8'h00
`define SCP_CFG_SOFTRST_HI   7
`define SCP_CFG_LSB_HI       6
`define SCP_CFG_STEP_HI      5
`define SCP_CFG_SDO_HI       4
`define SCP_CFG_SDO_LO       3
`define SCP_CFG_STEP_LO      2
`define SCP_CFG_LSB_LO       1
`define SCP_CFG_SOFTRST_LO   0
`define SCP_TUNE_ADDR        15'h0100
`define SCP_TUNE_BYTES       8
`define SCP_LOAD_ADDR        15'h0110
`define SCP_LOAD_MAIN_BIT    0
`define SCP_LOAD_CHAN_BIT    1
`define SCP_HREG_CTRL        12'h000
`define SCP_HREG_STAT        12'h004
`define SCP_HREG_DATA        12'h008
`define SCP_HREG_RDATA       12'h00c
`define SCP_HREG_CFG         12'h010
`define SCP_HALF_PERIOD      8'h07
`endif

// *** inc/scp_pkg.sv ***
`default_nettype none
package scp_pkg;
    typedef enum logic [1:0] {SCP_IDLE, SCP_LOW, SCP_HIGH, SCP_DONE} scp_hstate_t;
endpackage
`default_nettype wire

// *** inc/scp_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface scp_if;
    logic sclk;
    logic cs_n;
    logic sdio_host_o;
    logic sdio_host_oe;
    logic sdio_dev_o;
    logic sdio_dev_oe;
    logic sdio_i;
    logic separate_data_out;
    modport dev (input sclk, input cs_n, input sdio_i, output sdio_dev_o, output sdio_dev_oe, output separate_data_out);
    modport host (output sclk, output cs_n, output sdio_host_o, output sdio_host_oe, input sdio_i,
                  input separate_data_out);
endinterface
`default_nettype wire

// *** src/scp_device.sv ***
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "scp_defs.svh"
module scp_device
    import scp_pkg::*;
#(
    parameter int TUNE_BYTES = `SCP_TUNE_BYTES
)(
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ce,
    // Serial link.
    scp_if.dev              lnk,
    // User side.
    output logic [7:0]      cfg_out,
    output logic [7:0]      tune_out [TUNE_BYTES],
    output logic            soft_reset
);
    // ------------------------------------------------------------
    // Input synchronisers and edge detection.
    // ------------------------------------------------------------
    logic [1:0] sclk_s_r, cs_s_r, din_s_r;
    logic       sclk_d_r;
    // Only the second stage of each synchroniser is read.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sclk_s_r <= 2'h0;
            cs_s_r   <= 2'h3;
            din_s_r  <= 2'h0;
            sclk_d_r <= 1'b0;
        end
        else if (ce)
        begin
            sclk_s_r <= {sclk_s_r[0], lnk.sclk};
            cs_s_r   <= {cs_s_r[0], lnk.cs_n};
            din_s_r  <= {din_s_r[0], lnk.sdio_i};
            sclk_d_r <= sclk_s_r[1];
        end
    end
    wire sclk_q = sclk_s_r[1];
    wire cs_q   = cs_s_r[1];
    wire din_q  = din_s_r[1];
    wire rise   = ce & ~cs_q & sclk_q & ~sclk_d_r;
    wire fall   = ce & ~cs_q & ~sclk_q & sclk_d_r;
    // ------------------------------------------------------------
    // Frame state and registers.
    // ------------------------------------------------------------
    logic [4:0]  cnt_r;
    logic        instr_done_r;
    logic [15:0] sh_r;
    logic        rd_r;
    logic [14:0] addr_r;
    logic [7:0]  cfg_r;
    logic [7:0]  tshadow_r [TUNE_BYTES];
    logic [7:0]  tune_r [TUNE_BYTES];
    logic [7:0]  rbyte_r;
    logic [2:0]  rbit_r;
    logic        dout_r, oe_r, sdo_sel_r;
    // Configuration field decode, both mirrored copies must agree.
    wire lsb_first = cfg_r[`SCP_CFG_LSB_HI] & cfg_r[`SCP_CFG_LSB_LO];
    wire step_up   = cfg_r[`SCP_CFG_STEP_HI] & cfg_r[`SCP_CFG_STEP_LO];
    wire four_wire = cfg_r[`SCP_CFG_SDO_HI] & cfg_r[`SCP_CFG_SDO_LO];
    // Incoming bits enter from the top in LSB order, from the bottom otherwise.
    wire [15:0] sh_nxt = lsb_first ? {din_q, sh_r[15:1]} : {sh_r[14:0], din_q};
    wire [7:0]  byte_in = lsb_first ? sh_nxt[15:8] : sh_nxt[7:0];
    wire        byte_end = instr_done_r & (cnt_r[2:0] == 3'h7);
    wire        instr_end = ~instr_done_r & (cnt_r == 5'h0f);
    // Read mux over the mapped registers.
    function automatic logic [7:0] rd_mux(input logic [14:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == `SCP_CFG_ADDR)
            v = cfg_r;
        for (int i = 0; i < TUNE_BYTES; i++)
            if (a == `SCP_TUNE_ADDR + 15'(i))
                v = tune_r[i];
        return v;
    endfunction
    wire [7:0] rd_byte = rd_mux(addr_r);
    // The first nibble, put in upper-half form, is mirrored into the lower half.
    wire [3:0] nib      = lsb_first ? {byte_in[0], byte_in[1], byte_in[2], byte_in[3]} : byte_in[7:4];
    wire [7:0] cfg_wval = {nib, nib[0], nib[1], nib[2], nib[3]};
    wire [14:0] addr_step = step_up ? addr_r + 15'h1 : addr_r - 15'h1;
    wire        wr_hit    = rise & byte_end & ~rd_r;
    wire        load_req  = wr_hit & (addr_r == `SCP_LOAD_ADDR) &
                            (byte_in[`SCP_LOAD_MAIN_BIT] | byte_in[`SCP_LOAD_CHAN_BIT]);
    // ------------------------------------------------------------
    // Serial receive, write and address stepping.
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst | (ce & cs_q))
        begin
            cnt_r        <= 5'h00;
            instr_done_r <= 1'b0;
            sh_r         <= 16'h0000;
            if (rst)
            begin
                rd_r   <= 1'b0;
                addr_r <= 15'h0000;
                cfg_r  <= `SCP_CFG_RESET;
            end
        end
        else if (rise)
        begin
            sh_r  <= sh_nxt;
            cnt_r <= instr_end ? 5'h00 : cnt_r + 5'h01;
            if (instr_end)
            begin
                instr_done_r <= 1'b1;
                // Both shift directions leave the direction flag on top and the address below it.
                rd_r   <= sh_nxt[`SCP_DIR_BIT];
                addr_r <= sh_nxt[`SCP_ADDR_BITS-1:0];
            end
            if (byte_end)
            begin
                addr_r <= addr_step;
                if (~rd_r && addr_r == `SCP_CFG_ADDR)
                    cfg_r <= cfg_wval & ~8'h81;
            end
        end
    end
    // Tuning bytes land in a shadow and transfer together on a load request.
    genvar g;
    generate
        for (g = 0; g < TUNE_BYTES; g++)
        begin : g_tune
            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    tshadow_r[g] <= 8'h00;
                    tune_r[g]    <= 8'h00;
                end
                else
                begin
                    if (wr_hit && addr_r == `SCP_TUNE_ADDR + 15'(g))
                        tshadow_r[g] <= byte_in;
                    if (load_req)
                        tune_r[g] <= tshadow_r[g];
                end
            end
        end
    endgenerate
    // ------------------------------------------------------------
    // Read data launch on falling edges.
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst | (ce & cs_q))
        begin
            rbit_r    <= 3'h0;
            rbyte_r   <= 8'h00;
            dout_r    <= 1'b0;
            oe_r      <= 1'b0;
            sdo_sel_r <= 1'b0;
        end
        else if (fall && instr_done_r && rd_r)
        begin
            // A new byte is fetched at each byte boundary so stepped reads see fresh data.
            if (rbit_r == 3'h0)
            begin
                rbyte_r <= rd_byte;
                dout_r  <= lsb_first ? rd_byte[0] : rd_byte[7];
            end
            else
                dout_r  <= lsb_first ? rbyte_r[rbit_r] : rbyte_r[3'h7 - rbit_r];
            rbit_r    <= rbit_r + 3'h1;
            oe_r      <= ~four_wire;
            sdo_sel_r <= four_wire;
        end
    end
    // Outputs.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            lnk.sdio_dev_o        <= 1'b0;
            lnk.sdio_dev_oe       <= 1'b0;
            lnk.separate_data_out <= 1'b0;
            cfg_out               <= `SCP_CFG_RESET;
            soft_reset            <= 1'b0;
        end
        else if (ce)
        begin
            lnk.sdio_dev_o        <= dout_r;
            lnk.sdio_dev_oe       <= oe_r & ~cs_q;
            lnk.separate_data_out <= sdo_sel_r & ~cs_q & dout_r;
            cfg_out               <= cfg_r;
            soft_reset            <= wr_hit && addr_r == `SCP_CFG_ADDR && (cfg_wval[`SCP_CFG_SOFTRST_HI] |
                                     cfg_wval[`SCP_CFG_SOFTRST_LO]);
        end
    end
    assign tune_out = tune_r;
endmodule
`default_nettype wire

// *** src/scp_host.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "scp_defs.svh"
module scp_host
    import scp_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Serial link.
    scp_if.host              lnk
);
    // ------------------------------------------------------------
    // Registers: ctrl {start,last,rw,addr}, data, cfg {lsb,4wire}.
    // ------------------------------------------------------------
    scp_hstate_t st_r;
    logic [15:0] instr_r;
    logic [7:0]  wdata_r, rdata_r;
    logic [1:0]  cfg_r;
    logic        last_r, busy_r;
    logic [5:0]  bit_r;
    logic [7:0]  div_r;
    logic [23:0] sh_r;
    logic [1:0]  din_s_r;
    logic [1:0]  sdo_s_r;
    logic        start_r;
    wire acc   = psel & penable & ~pready;
    wire wr    = acc & pwrite;
    wire start = wr && paddr == `SCP_HREG_CTRL && pwdata[31] && !busy_r;
    wire tick  = ce && div_r == `SCP_HALF_PERIOD;
    wire lsb   = cfg_r[1];
    wire rd_op = instr_r[`SCP_DIR_BIT];
    wire [23:0] frame = {instr_r, wdata_r};
    wire [23:0] frame_rev = {<<{frame}};
    // An open frame skips its instruction, so each further start adds one data byte.
    wire        fresh     = lnk.cs_n;
    wire        rx_bit    = cfg_r[0] ? sdo_s_r[1] : din_s_r[1];
    wire [23:0] frame_ord = lsb ? {frame_rev[15:0], frame_rev[23:16]} : frame;
    wire [23:0] frame_cnt = {lsb ? frame_rev[23:16] : wdata_r, 16'h0000};
    wire [23:0] load_v    = fresh ? frame_ord : frame_cnt;
    // Register bus: one wait state, answers at second access edge.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pready <= 1'b0; prdata <= 32'h0; pslverr <= 1'b0;
            instr_r <= 16'h0; wdata_r <= 8'h0; cfg_r <= 2'h0; last_r <= 1'b1;
            start_r <= 1'b0;
        end
        else
        begin
            pready  <= acc;
            start_r <= start; // Delayed so the engine sees the new instruction.
            pslverr <= 1'b0;
            if (acc)
                case (paddr)
                    `SCP_HREG_CTRL:  prdata <= {busy_r, last_r, 14'h0, instr_r};
                    `SCP_HREG_STAT:  prdata <= {31'h0, busy_r};
                    `SCP_HREG_DATA:  prdata <= {24'h0, wdata_r};
                    `SCP_HREG_RDATA: prdata <= {24'h0, rdata_r};
                    `SCP_HREG_CFG:   prdata <= {30'h0, cfg_r};
                    default:         begin prdata <= 32'h0; pslverr <= 1'b1; end
                endcase
            if (wr && paddr == `SCP_HREG_CTRL && !busy_r)
            begin
                instr_r <= pwdata[15:0]; last_r <= pwdata[30];
            end
            if (wr && paddr == `SCP_HREG_DATA && !busy_r)
                wdata_r <= pwdata[7:0];
            if (wr && paddr == `SCP_HREG_CFG)
                cfg_r <= pwdata[1:0];
        end
    end
    // Serial engine: divider makes sclk, drive on fall, sample on rise.
    // The half period is long because the far end's synchronisers delay read data by about four clocks.
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_r <= SCP_IDLE; busy_r <= 1'b0; bit_r <= 6'h0; div_r <= 8'h0; sh_r <= 24'h0;
            din_s_r <= 2'h0; sdo_s_r <= 2'h0; rdata_r <= 8'h0;
            lnk.sclk <= 1'b0; lnk.cs_n <= 1'b1; lnk.sdio_host_o <= 1'b0; lnk.sdio_host_oe <= 1'b0;
        end
        else if (ce)
        begin
            din_s_r <= {din_s_r[0], lnk.sdio_i};
            sdo_s_r <= {sdo_s_r[0], lnk.separate_data_out};
            div_r   <= tick ? 8'h0 : div_r + 8'h1;
            case (st_r)
                SCP_IDLE:
                    if (start_r)
                    begin
                        busy_r <= 1'b1; lnk.cs_n <= 1'b0; div_r <= 8'h0;
                        bit_r <= fresh ? 6'd0 : 6'd16;
                        sh_r <= load_v; lnk.sdio_host_o <= load_v[23];
                        lnk.sdio_host_oe <= fresh | ~rd_op; st_r <= SCP_LOW;
                    end
                SCP_LOW:
                    if (tick)
                    begin
                        if (bit_r >= 6'd16 && rd_op)
                            rdata_r <= lsb ? {rx_bit, rdata_r[7:1]} : {rdata_r[6:0], rx_bit};
                        lnk.sclk <= 1'b1; st_r <= SCP_HIGH;
                    end
                SCP_HIGH:
                    if (tick)
                    begin
                        lnk.sclk <= 1'b0;
                        sh_r <= {sh_r[22:0], 1'b0};
                        lnk.sdio_host_o <= sh_r[22];
                        if (bit_r == 6'd15 && rd_op) lnk.sdio_host_oe <= 1'b0;
                        bit_r <= bit_r + 6'h1;
                        st_r <= (bit_r == 6'd23) ? SCP_DONE : SCP_LOW;
                    end
                SCP_DONE:
                begin
                    if (last_r) lnk.cs_n <= 1'b1;
                    lnk.sdio_host_oe <= 1'b0; busy_r <= 1'b0; st_r <= SCP_IDLE;
                end
                default: st_r <= SCP_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// *** dv/scp_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module scp_props (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst,
    // Serial link.
    input  wire logic sclk,
    input  wire logic cs_n,
    input  wire logic sdio_host_o,
    input  wire logic sdio_host_oe,
    input  wire logic sdio_dev_o,
    input  wire logic sdio_dev_oe,
    input  wire logic separate_data_out
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    logic [7:0] rise_cnt_r;
    logic       sclk_d_r;

    // ----------------------------------------
    // Serial clock rises counted within a frame
    // ----------------------------------------
    // The count saturates so that a runaway frame cannot wrap back into a legal length.
    always_ff @(posedge clk)
    begin
        sclk_d_r <= sclk;
        if (rst || cs_n)
            rise_cnt_r <= 8'h00;
        else if (sclk && !sclk_d_r && rise_cnt_r != 8'hff)
            rise_cnt_r <= rise_cnt_r + 8'h01;
    end

    // One serial clock high phase of eight system clocks, then low.
    sequence high_phase;
        sclk [*8] ##1 !sclk;
    endsequence

    // ----------------------------------------
    // Link assertions
    // ----------------------------------------
    idle_pin_free_a: assert property (cs_n [*4] |-> !sdio_dev_oe)
        else $error("device drives the shared pin while deselected");
    no_contention_a: assert property (!(sdio_host_oe && sdio_dev_oe))
        else $error("both ends drive the shared pin");
    read_after_instr_a: assert property (sdio_dev_oe && !cs_n |-> rise_cnt_r >= 8'd16)
        else $error("device drives before the instruction is complete");
    host_launch_a: assert property ($rose(sclk) && sdio_host_oe |-> $stable(sdio_host_o))
        else $error("host data changes at a rising serial clock");
    whole_bytes_a: assert property ($rose(cs_n) |-> rise_cnt_r >= 8'd24 && rise_cnt_r[2:0] == 3'd0)
        else $error("frame is not instruction plus whole bytes");
    clock_still_a: assert property (cs_n && $past(cs_n) |-> $stable(sclk))
        else $error("serial clock moves outside a frame");
    frame_start_a: assert property ($fell(cs_n) |-> ##[1:20] $rose(sclk))
        else $error("no serial clock after chip select falls");
    clock_rate_a: assert property ($rose(sclk) |-> high_phase)
        else $error("serial clock high phase has the wrong length");
endmodule
`default_nettype wire

// *** dv/test_serial_config_port.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "scp_defs.svh"
module test_serial_config_port
    import scp_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  cfg_out;
    logic [7:0]  tune_out [8];
    logic        soft_reset;
    logic        sdio_last = 1'b0;
    int          oe_cnt = 0;
    int          mark = 0;
    logic [31:0] rv;
    logic        ev;
    logic [7:0]  q;
    int          mismatches = 0;
    int          check_count = 0;
    int          cyc = 0;
    int          sr_seen = 0;

    scp_if lnk ();

    always #5 clk = ~clk;

    // No pull on the shared pin: when released it shows the inverse of its last level.
    assign lnk.sdio_i = lnk.sdio_host_oe ? lnk.sdio_host_o : lnk.sdio_dev_oe ? lnk.sdio_dev_o : ~sdio_last;

    scp_host i_scp_host (.clk(clk), .rst(rst), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(lnk.host));
    scp_device #(.TUNE_BYTES(8)) i_scp_device (.clk(clk), .rst(rst), .ce(1'b1), .lnk(lnk.dev),
        .cfg_out(cfg_out), .tune_out(tune_out), .soft_reset(soft_reset));
    scp_props i_scp_props (.clk(clk), .rst(rst), .sclk(lnk.sclk), .cs_n(lnk.cs_n), .sdio_host_o(lnk.sdio_host_o),
        .sdio_host_oe(lnk.sdio_host_oe), .sdio_dev_o(lnk.sdio_dev_o), .sdio_dev_oe(lnk.sdio_dev_oe),
        .separate_data_out(lnk.separate_data_out));

    // ----------------------------------------
    // Monitors and timeout
    // ----------------------------------------
    // The limit is well above the roughly 7000 cycles the sequence needs.
    always @(posedge clk)
    begin
        if (lnk.sdio_host_oe | lnk.sdio_dev_oe)
            sdio_last <= lnk.sdio_i;
        cyc <= cyc + 1;
        if (soft_reset === 1'b1)
            sr_seen <= sr_seen + 1;
        if (lnk.sdio_dev_oe === 1'b1)
            oe_cnt <= oe_cnt + 1;
        if (cyc == 50000)
        begin
            mismatches++;
            report_and_stop();
        end
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // One APB transfer; the request is held until pready is sampled high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // One serial byte; the instruction is sent only when the frame is new.
    task automatic byte_op(input logic rd, input logic [14:0] a, input logic [7:0] d, input logic last,
                           output logic [7:0] rq);
        logic [31:0] r;
        logic        e;
        apb(1'b1, `SCP_HREG_DATA, {24'h0, d}, r, e);
        apb(1'b1, `SCP_HREG_CTRL, {1'b1, last, 14'h0, rd, a}, r, e);
        do apb(1'b0, `SCP_HREG_STAT, 32'h0, r, e); while (r[0] !== 1'b0);
        rq = 8'h00;
        if (rd)
        begin
            apb(1'b0, `SCP_HREG_RDATA, 32'h0, r, e);
            rq = r[7:0];
        end
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(cfg_out, 32'h00);
        for (int i = 0; i < 8; i++) chk(tune_out[i], 32'h00);
        apb(1'b0, 12'hffc, 32'h0, rv, ev);
        chk(ev, 1'b1);
        // Config lands at the end of its byte while the frame is still open.
        byte_op(1'b0, `SCP_CFG_ADDR, 8'h24, 1'b0, q);
        chk(cfg_out, 32'h24);
        chk(lnk.cs_n, 1'b0);
        byte_op(1'b0, 15'h0001, 8'h55, 1'b1, q);
        for (int i = 0; i < 8; i++) byte_op(1'b0, `SCP_TUNE_ADDR, 8'h10 + 8'(i), i == 7, q);
        chk(tune_out[0], 32'h00);
        byte_op(1'b0, `SCP_LOAD_ADDR, 8'h03, 1'b1, q);
        for (int i = 0; i < 8; i++) chk(tune_out[i], 32'h10 + i);
        mark = oe_cnt;
        for (int i = 0; i < 3; i++)
        begin
            byte_op(1'b1, `SCP_TUNE_ADDR, 8'h00, i == 2, q);
            chk(q, 32'h10 + i);
        end
        chk({31'h0, oe_cnt != mark}, 32'h1);
        // Step down from the top tuning byte.
        byte_op(1'b0, `SCP_CFG_ADDR, 8'h00, 1'b1, q);
        byte_op(1'b0, `SCP_TUNE_ADDR + 15'd7, 8'ha7, 1'b0, q);
        byte_op(1'b0, 15'h0, 8'ha6, 1'b1, q);
        byte_op(1'b0, `SCP_LOAD_ADDR, 8'h03, 1'b1, q);
        chk(tune_out[7], 32'ha7);
        chk(tune_out[6], 32'ha6);
        // Low bit first; a non-palindromic byte shows the order.
        byte_op(1'b0, `SCP_CFG_ADDR, 8'h66, 1'b1, q);
        apb(1'b1, `SCP_HREG_CFG, 32'h2, rv, ev);
        byte_op(1'b0, `SCP_TUNE_ADDR + 15'd2, 8'h1d, 1'b1, q);
        byte_op(1'b0, `SCP_LOAD_ADDR, 8'h03, 1'b1, q);
        chk(tune_out[2], 32'h1d);
        byte_op(1'b1, `SCP_CFG_ADDR, 8'h00, 1'b1, q);
        chk(q, 32'h66);
        // Four-wire read leaves the shared pin to the host.
        byte_op(1'b0, `SCP_CFG_ADDR, 8'h7e, 1'b1, q);
        apb(1'b1, `SCP_HREG_CFG, 32'h3, rv, ev);
        mark = oe_cnt;
        byte_op(1'b1, `SCP_TUNE_ADDR + 15'd1, 8'h00, 1'b1, q);
        chk(q, 32'h11);
        chk({31'h0, oe_cnt != mark}, 32'h0);
        mark = sr_seen;
        byte_op(1'b0, `SCP_CFG_ADDR, 8'hff, 1'b1, q);
        chk(sr_seen - mark, 32'd1);
        report_and_stop();
    end
endmodule
`default_nettype wire
